//--- rrcs_map.vh
// rrcs_map.vh: constants of the reset release and clock start-up sequencer
// assumes: included by bare name from the rrcs top-level design file only
`ifndef RRCS_MAP_VH
`define RRCS_MAP_VH

// ********************
// timing
// ********************
`define RRCS_CLK_MHZ          250
`define RRCS_T_POR_US         10
`define RRCS_T_START_REG_US   20
`define RRCS_T_START_NOREG_US 64000
`define RRCS_T_RST_US         20
`define RRCS_T_LOCK_US        20
`define RRCS_T_MON_US         500
`define RRCS_OST_PERIODS      1024

// ********************
// oscillator source codes
// ********************
`define RRCS_OSC_FRC     3'h0
`define RRCS_OSC_FRCPLL  3'h1
`define RRCS_OSC_EXT     3'h2
`define RRCS_OSC_EXTPLL  3'h3
`define RRCS_OSC_XTAL    3'h4
`define RRCS_OSC_XTALPLL 3'h5
`define RRCS_OSC_SEC     3'h6
`define RRCS_OSC_LOW_POWER_INTERNAL_RC    3'h7

// ********************
// register offsets (byte addresses)
// ********************
`define RRCS_OFS_CAUSE    8'h00
`define RRCS_OFS_OSC_CTRL 8'h04
`define RRCS_OFS_STATUS   8'h08
`define RRCS_OFS_IRQ_STAT 8'h0C
`define RRCS_OFS_IRQ_MASK 8'h10

// ********************
// reset cause register fields
// ********************
`define RRCS_CB_TRAP   15
`define RRCS_CB_IOP    14
`define RRCS_CB_CM     9
`define RRCS_CB_EXT    7
`define RRCS_CB_INSTR  6
`define RRCS_CB_WDT    4
`define RRCS_CB_BOR    1
`define RRCS_CB_POR    0
`define RRCS_CAUSE_IMPL 16'hC2D3
`define RRCS_CAUSE_RST  16'h0003

// ********************
// osc control and interrupt fields
// ********************
`define RRCS_OC_FAIL    3
`define RRCS_IRQ_W      3
`define RRCS_IRQ_RSTREL 0
`define RRCS_IRQ_CLKREL 1
`define RRCS_IRQ_FAIL   2
`define RRCS_MASK_RST   3'h0

`endif

//--- rrcs_dly_timer.v
// rrcs_dly_timer.v: loadable down counter used for every nominal delay
// assumes: step_i is a one-cycle enable pulse in the caller's time base
module rrcs_dly_timer #(
  parameter W = 17
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         srst_i,
  // control
  input  wire         load_i,
  input  wire [W-1:0] load_val_i,
  input  wire         step_i,
  // state
  output wire         done_o
);

  reg [W-1:0] cnt_ff;   // remaining steps
  reg         busy_ff;  // counting in progress
  reg         done_ff;  // sticky until next load

  // ****************************************************************
  // counter
  // ****************************************************************
  // load restarts; done holds so the caller may sample it late
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_ff  <= {W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (load_i) begin
      cnt_ff  <= load_val_i;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff && step_i) begin
      // last step ends the delay
      if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign done_o = done_ff;

endmodule // rrcs_dly_timer

//--- rrcs_top.v
// rrcs_top.v: reset release sequencer with clock start-up and fail monitor
// assumes: reset sources, ticks and config levels are synchronous to sys_clk_i;
// osc_tick_i pulses once per oscillator period; apb master per AMBA APB
`include "rrcs_map.vh"

// Operation
// [R1] switching on: POR/BOR use config, else current
// [R2] switching off: config bits always pick clock
// [R3] release reset after power-on and startup delays
// [R4] clock start-up runs alongside reset delays
// [R5] POR: 10us, startup, internal; BOR skips 10us
// [R6] startup 20us regulated, 64ms not; wake too (code applies no wake delay with regulator off)
// [R7] other resets: internal reset time only
// [R8] crystal sources count 1024 oscillator periods
// [R9] PLL sources wait lock time after start-up
// [R10] crystal/PLL: monitor arms after extra delay
// [R11] no execution before clock is released
// [R12] no clock at arming: switch to FAST_INTERNAL_RC, trap
// [R13] osc control reset depends on type, config
// [R14] any active source asserts master reset
// [R15] own cause flags; POR clears others
// [R16] delays count a microsecond timebase
module rrcs_top #(
  parameter [16:0] T_POR_US         = `RRCS_T_POR_US,
  parameter [16:0] T_START_REG_US   = `RRCS_T_START_REG_US,
  parameter [16:0] T_START_NOREG_US = `RRCS_T_START_NOREG_US,
  parameter [16:0] T_RST_US         = `RRCS_T_RST_US,
  parameter [16:0] T_LOCK_US        = `RRCS_T_LOCK_US,
  parameter [16:0] T_MON_US         = `RRCS_T_MON_US,
  parameter [16:0] OST_PERIODS      = `RRCS_OST_PERIODS
) (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        srst_i,
  // reset sources, high while active
  input  wire        por_rst_i,
  input  wire        brownout_reset_i,
  input  wire        external_clear_pin_reset_i,
  input  wire        watchdog_reset_i,
  input  wire        instruction_reset_i,
  input  wire        trap_conflict_rst_i,
  input  wire        illegal_op_rst_i,
  input  wire        cfg_mismatch_rst_i,
  // configuration levels
  input  wire        clk_switch_en_i,
  input  wire [2:0]  initial_osc_select_field_i,
  input  wire        regulator_en_i,
  input  wire        clock_fail_monitor_en_i,
  // oscillator side
  input  wire        osc_tick_i,
  input  wire        clk_valid_i,
  input  wire        wake_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // sequencer outputs
  output reg         master_reset_line_o,
  output reg  [2:0]  clk_sel_o,
  output reg         clk_released_o,
  output reg         exec_en_o,
  output reg         monitor_armed_o,
  output reg         osc_fail_trap_o,
  output reg         irq_o
);

  // ****************************************************************
  // local codes
  // ****************************************************************
  localparam [2:0] S_HOLD  = 3'h0;  // source active
  localparam [2:0] S_POR   = 3'h1;  // power-on delay
  localparam [2:0] S_START = 3'h2;  // start-up delay
  localparam [2:0] S_RST   = 3'h3;  // internal reset time
  localparam [2:0] S_RUN   = 3'h4;  // released
  localparam [2:0] S_WAKE  = 3'h5;  // start-up after sleep
  localparam [1:0] K_POR   = 2'h0;  // kinds, lower wins
  localparam [1:0] K_BOR   = 2'h1;
  localparam [1:0] K_SHORT = 2'h2;
  localparam [1:0] CK_RUN  = 2'h0;  // clock chain states
  localparam [1:0] CK_OST  = 2'h1;
  localparam [1:0] CK_LOCK = 2'h2;
  localparam [1:0] M_OFF   = 2'h0;  // monitor states
  localparam [1:0] M_WAIT  = 2'h1;
  localparam [1:0] M_CHECK = 2'h2;
  localparam [1:0] M_ARMED = 2'h3;
  localparam [7:0] DIV_LAST = `RRCS_CLK_MHZ * 1 - 1;  // cycles per us, less one

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function is_xtal;  // sources needing the start-up count
    input [2:0] s;
    is_xtal = (s == `RRCS_OSC_XTAL) || (s == `RRCS_OSC_XTALPLL) ||
              (s == `RRCS_OSC_SEC);
  endfunction

  function is_pll;  // sources needing lock time
    input [2:0] s;
    is_pll = (s == `RRCS_OSC_FRCPLL) || (s == `RRCS_OSC_EXTPLL) ||
             (s == `RRCS_OSC_XTALPLL);
  endfunction

  function addr_hit;  // mapped register offsets
    input [7:0] a;
    addr_hit = (a == `RRCS_OFS_CAUSE) || (a == `RRCS_OFS_OSC_CTRL) ||
               (a == `RRCS_OFS_STATUS) || (a == `RRCS_OFS_IRQ_STAT) ||
               (a == `RRCS_OFS_IRQ_MASK);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg [7:0]  div_ff;       // microsecond divider
  reg        us_tick_ff;   // one pulse per microsecond
  reg [2:0]  state_ff;     // reset chain
  reg [1:0]  kind_ff;      // kind of the current reset
  reg [1:0]  ck_ff;        // clock chain
  reg        clk_ok_ff;    // clock released to system
  reg [1:0]  mon_ff;       // fail monitor
  reg [2:0]  cur_osc_ff;   // current source field
  reg        fail_ff;      // clock failure seen
  reg [15:0] cause_ff;     // reset cause flags
  reg [2:0]  irq_st_ff;    // sticky events
  reg [2:0]  mask_ff;      // event enables

  reg [2:0]  nxt_state;
  reg [1:0]  nxt_kind;
  reg [1:0]  nxt_ck;
  reg        nxt_clk_ok;
  reg [1:0]  nxt_mon;
  reg [2:0]  nxt_cur_osc;
  reg        nxt_fail;
  reg        fail_evt;
  reg        r_load;       // reset chain timer
  reg [16:0] r_val;
  reg        c_load;       // clock chain timer
  reg [16:0] c_val;
  reg        m_load;       // monitor delay timer
  reg [2:0]  sel_osc;      // source picked at release
  wire       r_done;
  wire       c_done;
  wire       m_done;

  // ****************************************************************
  // source merge and bus decode
  // ****************************************************************
  wire any_src = por_rst_i | brownout_reset_i | external_clear_pin_reset_i |
                 watchdog_reset_i | instruction_reset_i | trap_conflict_rst_i |
                 illegal_op_rst_i | cfg_mismatch_rst_i;  // [R14]
  wire [1:0] src_kind = por_rst_i ? K_POR : (brownout_reset_i ? K_BOR : K_SHORT);
  wire bus_wr = psel_i & penable_i & pwrite_i & pready_o & addr_hit(paddr_i);
  wire wr_cause = bus_wr & (paddr_i == `RRCS_OFS_CAUSE);
  wire wr_osc   = bus_wr & (paddr_i == `RRCS_OFS_OSC_CTRL);
  wire wr_stat  = bus_wr & (paddr_i == `RRCS_OFS_IRQ_STAT);
  wire wr_mask  = bus_wr & (paddr_i == `RRCS_OFS_IRQ_MASK);
  wire [16:0] t_start = regulator_en_i ? T_START_REG_US : T_START_NOREG_US;  // [R6]
  wire nxt_mreset = (nxt_state != S_RUN) && (nxt_state != S_WAKE);

  // ****************************************************************
  // microsecond timebase
  // ****************************************************************
  // all nominal delays count this tick, not raw cycles
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      div_ff     <= 8'h00;
      us_tick_ff <= 1'b0;
    end else if (div_ff == DIV_LAST) begin
      div_ff     <= 8'h00;
      us_tick_ff <= 1'b1;  // [R16]
    end else begin
      div_ff     <= div_ff + 8'h01;
      us_tick_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // delay timers
  // ****************************************************************
  rrcs_dly_timer #(.W(17)) u_rst_tmr (
    .sys_clk_i  (sys_clk_i),
    .srst_i     (srst_i),
    .load_i     (r_load),
    .load_val_i (r_val),
    .step_i     (us_tick_ff),
    .done_o     (r_done)
  );

  // start-up count steps on oscillator periods, lock on microseconds
  rrcs_dly_timer #(.W(17)) u_clk_tmr (
    .sys_clk_i  (sys_clk_i),
    .srst_i     (srst_i),
    .load_i     (c_load),
    .load_val_i (c_val),
    .step_i     ((ck_ff == CK_OST) ? osc_tick_i : us_tick_ff),  // [R8]
    .done_o     (c_done)
  );

  rrcs_dly_timer #(.W(17)) u_mon_tmr (
    .sys_clk_i  (sys_clk_i),
    .srst_i     (srst_i),
    .load_i     (m_load),
    .load_val_i (T_MON_US),
    .step_i     (us_tick_ff),
    .done_o     (m_done)
  );

  // ****************************************************************
  // sequencer next state
  // ****************************************************************
  // clock chain first, reset chain may restart it, monitor overrides both
  always @* begin
    nxt_state   = state_ff;
    nxt_kind    = kind_ff;
    nxt_ck      = ck_ff;
    nxt_clk_ok  = clk_ok_ff;
    nxt_mon     = mon_ff;
    nxt_cur_osc = cur_osc_ff;
    nxt_fail    = fail_ff & ~(wr_osc & pwdata_i[`RRCS_OC_FAIL]);
    fail_evt    = 1'b0;
    r_load      = 1'b0;
    r_val       = T_RST_US;
    c_load      = 1'b0;
    c_val       = T_LOCK_US;
    m_load      = 1'b0;
    // pll sources get lock time; crystal plain sources are done
    sel_osc     = (clk_switch_en_i && kind_ff == K_SHORT) ?
                  cur_osc_ff : initial_osc_select_field_i;  // [R1] [R2]
    // clock chain progress
    case (ck_ff)
      CK_OST: begin
        if (c_done) begin
          if (is_pll(cur_osc_ff)) begin
            nxt_ck = CK_LOCK;  // [R9]
            c_load = 1'b1;
          end else begin
            nxt_ck     = CK_RUN;
            nxt_clk_ok = 1'b1;
          end
        end
      end
      CK_LOCK: begin
        if (c_done) begin
          nxt_ck     = CK_RUN;
          nxt_clk_ok = 1'b1;  // [R9]
        end
      end
      default: ;
    endcase
    // reset chain
    if (any_src) begin
      nxt_state = S_HOLD;  // [R14]
      nxt_kind  = (state_ff != S_HOLD || src_kind < kind_ff) ? src_kind : kind_ff;
      nxt_mon   = M_OFF;
      nxt_fail  = 1'b0;
    end else begin
      case (state_ff)
        S_HOLD: begin
          r_load      = 1'b1;
          nxt_cur_osc = sel_osc;  // [R13]
          if (kind_ff == K_POR) begin
            nxt_state = S_POR;  // [R5]
            r_val     = T_POR_US;
          end else if (kind_ff == K_BOR) begin
            nxt_state = S_START;  // [R5]
            r_val     = t_start;
          end else begin
            nxt_state = S_RST;  // [R7]
          end
          // clock start-up begins now, in parallel with the delays
          if (kind_ff == K_SHORT) begin
            nxt_ck     = CK_RUN;  // [R7]
            nxt_clk_ok = 1'b1;
          end else if (is_xtal(sel_osc)) begin
            nxt_ck     = CK_OST;  // [R4] [R8]
            nxt_clk_ok = 1'b0;
            c_load     = 1'b1;
            c_val      = OST_PERIODS;
          end else if (is_pll(sel_osc)) begin
            nxt_ck     = CK_LOCK;  // [R4] [R9]
            nxt_clk_ok = 1'b0;
            c_load     = 1'b1;
          end else begin
            nxt_ck     = CK_RUN;
            nxt_clk_ok = 1'b1;
          end
        end
        S_POR: begin
          if (r_done) begin
            nxt_state = S_START;  // [R5]
            r_load    = 1'b1;
            r_val     = t_start;
          end
        end
        S_START: begin
          if (r_done) begin
            nxt_state = S_RST;  // [R5]
            r_load    = 1'b1;
          end
        end
        S_RST: begin
          if (r_done) begin
            nxt_state = S_RUN;  // [R3]
            if (clock_fail_monitor_en_i) begin
              if (kind_ff != K_SHORT &&
                  (is_xtal(cur_osc_ff) || is_pll(cur_osc_ff))) begin
                nxt_mon = M_WAIT;  // [R10]
                m_load  = 1'b1;
              end else begin
                nxt_mon = M_CHECK;
              end
            end
          end
        end
        S_RUN: begin
          // regulator off: wake start-up is not applied
          if (wake_i && regulator_en_i) begin
            nxt_state = S_WAKE;  // [R6]
            r_load    = 1'b1;
            r_val     = T_START_REG_US;
          end
        end
        S_WAKE: begin
          if (r_done) begin
            nxt_state = S_RUN;
          end
        end
        default: begin
          nxt_state = S_HOLD;
        end
      endcase
    end
    // fail monitor
    if (!any_src) begin
      case (mon_ff)
        M_WAIT: begin
          if (m_done) begin
            nxt_mon = M_CHECK;  // [R10]
          end
        end
        M_CHECK: begin
          if (!(clk_ok_ff && clk_valid_i)) begin
            fail_evt = 1'b1;  // [R12]
          end else begin
            nxt_mon = M_ARMED;
          end
        end
        M_ARMED: begin
          if (!clk_valid_i) begin
            fail_evt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // fall back to the fast internal rc
    if (fail_evt) begin
      nxt_cur_osc = `RRCS_OSC_FRC;  // [R12]
      nxt_ck      = CK_RUN;
      nxt_clk_ok  = 1'b1;
      nxt_fail    = 1'b1;
      nxt_mon     = M_OFF;
    end
  end

  // ****************************************************************
  // sequencer registers and outputs
  // ****************************************************************
  // after srst the chain behaves as a power-on
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_ff            <= S_HOLD;
      kind_ff             <= K_POR;
      ck_ff               <= CK_RUN;
      clk_ok_ff           <= 1'b0;
      mon_ff              <= M_OFF;
      cur_osc_ff          <= `RRCS_OSC_FRC;
      fail_ff             <= 1'b0;
      master_reset_line_o <= 1'b1;
      clk_sel_o           <= `RRCS_OSC_FRC;
      clk_released_o      <= 1'b0;
      exec_en_o           <= 1'b0;
      monitor_armed_o     <= 1'b0;
      osc_fail_trap_o     <= 1'b0;
    end else begin
      state_ff            <= nxt_state;
      kind_ff             <= nxt_kind;
      ck_ff               <= nxt_ck;
      clk_ok_ff           <= nxt_clk_ok;
      mon_ff              <= nxt_mon;
      cur_osc_ff          <= nxt_cur_osc;
      fail_ff             <= nxt_fail;
      master_reset_line_o <= nxt_mreset;  // [R3] [R14]
      clk_sel_o           <= nxt_cur_osc;
      clk_released_o      <= nxt_clk_ok;
      exec_en_o           <= (nxt_state == S_RUN) && nxt_clk_ok;  // [R11]
      monitor_armed_o     <= (nxt_mon == M_ARMED);
      osc_fail_trap_o     <= fail_evt;  // [R12]
    end
  end

  // ****************************************************************
  // reset cause flags
  // ****************************************************************
  // hardware set beats a simultaneous software clear
  wire [15:0] cause_set = ({15'h0, por_rst_i} << `RRCS_CB_POR) |
                          ({15'h0, brownout_reset_i} << `RRCS_CB_BOR) |
                          ({15'h0, external_clear_pin_reset_i} << `RRCS_CB_EXT) |
                          ({15'h0, watchdog_reset_i} << `RRCS_CB_WDT) |
                          ({15'h0, instruction_reset_i} << `RRCS_CB_INSTR) |
                          ({15'h0, trap_conflict_rst_i} << `RRCS_CB_TRAP) |
                          ({15'h0, illegal_op_rst_i} << `RRCS_CB_IOP) |
                          ({15'h0, cfg_mismatch_rst_i} << `RRCS_CB_CM);
  wire [15:0] cause_base = wr_cause ? (pwdata_i[15:0] & `RRCS_CAUSE_IMPL) : cause_ff;

  // flags are status only: writing one never starts a reset
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      cause_ff <= `RRCS_CAUSE_RST;
    end else if (por_rst_i) begin
      cause_ff <= cause_set & (16'h0001 << `RRCS_CB_POR);  // [R15]
    end else begin
      cause_ff <= cause_base | cause_set;  // [R15]
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  wire [2:0] ev = {fail_evt, nxt_clk_ok & ~clk_ok_ff,
                   master_reset_line_o & ~nxt_mreset};

  // plain registers take the same value on every reset kind
  always @(posedge sys_clk_i) begin
    if (srst_i || any_src) begin
      irq_st_ff <= 3'h0;  // [R13]
      mask_ff   <= `RRCS_MASK_RST;
      irq_o     <= 1'b0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~(wr_stat ? pwdata_i[2:0] : 3'h0)) | ev;
      mask_ff   <= wr_mask ? pwdata_i[2:0] : mask_ff;
      irq_o     <= |((irq_st_ff & ~(wr_stat ? pwdata_i[2:0] : 3'h0) | ev) &
                     (wr_mask ? pwdata_i[2:0] : mask_ff));
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // one wait-free access phase: data captured in setup, ready next cycle
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h00000000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pready_o  <= 1'b1;
      pslverr_o <= ~addr_hit(paddr_i);
      case (paddr_i)
        `RRCS_OFS_CAUSE:    prdata_o <= {16'h0000, cause_ff};
        `RRCS_OFS_OSC_CTRL: prdata_o <= {17'h00000, cur_osc_ff, 8'h00, fail_ff,
                                         2'h0, clk_ok_ff};
        `RRCS_OFS_STATUS:   prdata_o <= {24'h000000, mon_ff, ck_ff, exec_en_o,
                                         state_ff};
        `RRCS_OFS_IRQ_STAT: prdata_o <= {29'h00000000, irq_st_ff};
        `RRCS_OFS_IRQ_MASK: prdata_o <= {29'h00000000, mask_ff};
        default:            prdata_o <= 32'h00000000;
      endcase
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule // rrcs_top

//--- rrcs_checker.sv
// rrcs_checker.sv: timing assertions on the ports of the reset release sequencer
// assumes: bound to rrcs_top, one clock domain, srst_i synchronous active high
module rrcs_checker #(
  parameter [16:0] T_RST_US = 20
) (
  input wire logic       sys_clk_i, srst_i, por_rst_i, brownout_reset_i,
  input wire logic       external_clear_pin_reset_i, watchdog_reset_i,
  input wire logic       instruction_reset_i, trap_conflict_rst_i,
  input wire logic       illegal_op_rst_i, cfg_mismatch_rst_i, clk_switch_en_i,
  input wire logic [2:0] initial_osc_select_field_i, clk_sel_o,
  input wire logic       master_reset_line_o, clk_released_o, exec_en_o,
  input wire logic       monitor_armed_o, osc_fail_trap_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ********************
  // helper: cycles since the last active source
  // ********************
  wire any_src = por_rst_i | brownout_reset_i | external_clear_pin_reset_i |
                 watchdog_reset_i | instruction_reset_i | trap_conflict_rst_i |
                 illegal_op_rst_i | cfg_mismatch_rst_i;
  logic [15:0] quiet_ff;
  // saturating, so a long quiet spell never wraps into a false short hold
  always @(posedge sys_clk_i) begin
    quiet_ff <= (srst_i | any_src) ? 16'h0 : quiet_ff + {15'h0, quiet_ff != 16'hFFFF};
  end
  sequence s_rel; $fell(master_reset_line_o); endsequence
  sequence s_trap; osc_fail_trap_o; endsequence
  // ********************
  // properties
  // ********************
  a_src_hold_rst: assert property (any_src |=> master_reset_line_o)
    else $error("reset low with source active");
  a_rel_min_hold: assert property (s_rel |-> quiet_ff >= (T_RST_US - 17'd1) * 250)
    else $error("reset released early");
  a_exec_needs_clk: assert property (exec_en_o |-> clk_released_o && !master_reset_line_o)
    else $error("exec without clock");
  a_trap_one_pulse: assert property (s_trap |=> !osc_fail_trap_o)
    else $error("trap too long");
  a_trap_to_frc: assert property (s_trap |-> ##[0:1] (clk_sel_o == 3'h0 && clk_released_o))
    else $error("no fast rc fallback");
  a_trap_disarm: assert property (s_trap |=> !monitor_armed_o)
    else $error("armed after fail");
  a_sel_fixed: assert property (s_rel ##0 !clk_switch_en_i |->
    clk_sel_o == initial_osc_select_field_i)
    else $error("source not from config");
  a_arm_after_rel: assert property (monitor_armed_o |-> !master_reset_line_o)
    else $error("armed in reset");
endmodule // rrcs_checker

bind rrcs_top rrcs_checker #(.T_RST_US(T_RST_US)) u_chk (.*);

//--- rrcs_osc_model.sv
// rrcs_osc_model.sv: oscillator stand-in giving period ticks and a clock-good level
// assumes: one tick every second system cycle; fail_i from the bench kills the clock
module rrcs_osc_model (
  input  wire logic sys_clk_i,
  input  wire logic fail_i,
  output logic      tick_o = 1'b0,
  output logic      valid_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ticks keep running even when failed: the monitor must use the level
  always @(posedge sys_clk_i) begin
    tick_o  <= ~tick_o;
    valid_o <= ~fail_i;
  end
endmodule // rrcs_osc_model

//--- rrcs_top_tb.sv
// rrcs_top_tb.sv: self-checking bench for the reset release sequencer
// assumes: rrcs_osc_model and rrcs_checker compiled before it
module rrcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int US = 250;  // cycles per microsecond
  logic sys_clk_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0, sw_en = 1, fail = 0, sl, reg_en = 1;
  logic [7:0] src = 0, paddr = 0;
  logic [2:0] cfg = 3'h4;
  logic [31:0] pwdata = 0, rd, r, seed = 32'hCF19;
  wire [31:0] prdata;
  wire [2:0] sel;
  wire pready, pslverr, mrst, crel, exe, arm, trap, irq, tick, cval;
  int err_count = 0, checks = 0, n, k;
  logic [31:0] exp_cause = 32'h3;
  int cb[8] = '{0, 1, 7, 4, 6, 15, 14, 9};  // cause bit of each source
  always #2 sys_clk_i = ~sys_clk_i;
  rrcs_osc_model osc (.sys_clk_i(sys_clk_i), .fail_i(fail), .tick_o(tick), .valid_o(cval));
  rrcs_top #(.T_START_NOREG_US(17'd30), .T_MON_US(17'd5)) dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .por_rst_i(src[0]), .brownout_reset_i(src[1]),
    .external_clear_pin_reset_i(src[2]), .watchdog_reset_i(src[3]),
    .instruction_reset_i(src[4]), .trap_conflict_rst_i(src[5]), .illegal_op_rst_i(src[6]),
    .cfg_mismatch_rst_i(src[7]), .clk_switch_en_i(sw_en), .initial_osc_select_field_i(cfg),
    .regulator_en_i(reg_en), .clock_fail_monitor_en_i(1'b1), .osc_tick_i(tick),
    .clk_valid_i(cval), .wake_i(1'b0), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .master_reset_line_o(mrst), .clk_sel_o(sel), .clk_released_o(crel),
    .exec_en_o(exe), .monitor_armed_o(arm), .osc_fail_trap_o(trap), .irq_o(irq));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // apb master: hold the request until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d; pen <= 0;
    @(posedge sys_clk_i) pen <= 1;
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    sl = pslverr;
    psel <= 0; pen <= 0;
    if (n >= 50) begin err_count++; end_of_test(); end
    @(posedge sys_clk_i);
  endtask
  // count cycles from source drop to release, allowing one us of tick phase
  task automatic wait_rel(int us);
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (mrst !== 1'b0 && n < 40000);
    checks++;
    if (n < (us - 1) * US || n > (us + 1) * US + 4) begin
      err_count++;
      $display("[FAIL] release cycles expected %0d seen %0d", us * US, n);
      if (n >= 40000) end_of_test();
    end
    chk("clock at release", 1, crel);
    repeat (3) @(posedge sys_clk_i);
    chk("exec after release", 1, exe);
  endtask
  task automatic fire(int s, int us);
    src[s] <= 1;
    repeat (2 + xs() % 8) @(posedge sys_clk_i);
    src[s] <= 0;
    wait_rel(us);
    exp_cause = (s == 0) ? 32'h1 : exp_cause | (32'h1 << cb[s]);
    apb(0, 8'h00, 0);
    chk("cause", exp_cause, rd);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 0;
    wait_rel(50);
    apb(0, 8'h00, 0);
    chk("cause after power up", exp_cause, rd);
    repeat (US) @(posedge sys_clk_i);
    chk("monitor waits", 0, arm);
    repeat (6 * US) @(posedge sys_clk_i);
    chk("monitor armed", 1, arm);
    cfg <= 3'h6;
    for (k = 2; k < 8; k++) begin
      fire(k, 20);
      chk("clock kept on short reset", 3'h4, sel);
    end
    reg_en <= 0;
    fire(1, 50);
    chk("config clock on brownout", 3'h6, sel);
    reg_en <= 1;
    sw_en <= 0;
    cfg <= 3'h2;
    fire(3, 20);
    chk("config clock, switching off", 3'h2, sel);
    fire(0, 50);
    r = xs();
    apb(1, 8'h10, r);
    apb(0, 8'h10, 0);
    chk("irq mask", {29'h0, r[2:0]}, rd);
    apb(1, 8'h10, 32'h4);
    apb(1, 8'h0C, 32'h7);
    repeat (2) @(posedge sys_clk_i);
    chk("irq idle", 0, irq);
    fail <= 1;
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (trap !== 1'b1 && n < 20);
    chk("fail trap", 1, trap);
    repeat (3) @(posedge sys_clk_i);
    chk("fallback source", 3'h0, sel);
    chk("irq on fail", 1, irq);
    apb(0, 8'h04, 0);
    chk("fail flag", 1, rd[3]);
    apb(1, 8'h0C, 32'h4);
    repeat (3) @(posedge sys_clk_i);
    chk("irq cleared", 0, irq);
    apb(0, 8'h40, 0);
    chk("unmapped error", 1, sl);
    end_of_test();
  end
endmodule // rrcs_top_tb
